// [rtl/abt_pkg.sv]
package abt_pkg;
    // register addresses on the special-function bus
    localparam logic [7:0] ADDR_POWERUP_TIME = 8'h_BA;
    localparam logic [7:0] ADDR_TRACK_TIME   = 8'h_BD;
    localparam logic [7:0] POWERUP_RESET     = 8'h_0F;
    localparam logic [7:0] TRACK_RESET       = 8'h_16;
    localparam int         POWERUP_MSB       = 3;
    localparam int         TRACK_MSB         = 5;
    // time steps
    localparam int         CLK_PERIOD_PS     = 5000;
    localparam int         POWERUP_STEP_PS   = 400000;
    localparam int         TRACK_STEP_PS     = 50000;
    localparam int         POWERUP_STEP_CYC  = POWERUP_STEP_PS / CLK_PERIOD_PS;
    localparam int         TRACK_STEP_CYC    = TRACK_STEP_PS / CLK_PERIOD_PS;
    localparam logic [6:0] TRACK_BASE        = 7'h_40;
    localparam logic [1:0] DELAYED_TRACK_CYC = 2'h_3;
    localparam logic [6:0] STEP_CNT_RESET    = 7'h_00;

    typedef enum logic [2:0] {
        ABT_IDLE    = 3'b000,
        ABT_POWERUP = 3'b001,
        ABT_TRACK   = 3'b010,
        ABT_EXTRA   = 3'b011,
        ABT_CONVERT = 3'b100
    } abt_state_e;
endpackage

// [rtl/abt_burst_timing.sv]
`timescale 1ns/1ps
`default_nettype none
module abt_burst_timing (
    input  wire logic       clk_sys,
    input  wire logic       sys_rst,
    input  wire logic [7:0] sfr_addr,
    input  wire logic       sfr_page_f,
    input  wire logic       sfr_wr,
    input  wire logic [7:0] sfr_wdata,
    output logic      [7:0] sfr_rdata,
    input  wire logic       burst_mode_on,
    input  wire logic       converter_enable_bit,
    input  wire logic       delayed_tracking_option,
    input  wire logic [2:0] burst_repeat_field,
    input  wire logic       start_conv,
    input  wire logic       sar_clk_tick,
    input  wire logic       conv_done,
    output logic            adc_powered,
    output logic            conv_start,
    output logic            clk_from_lp_osc,
    output logic            burst_busy
);
    logic [3:0]             powerup_delay_field_reg;
    logic [5:0]             track_delay_field_reg;
    abt_pkg::abt_state_e    state_reg;
    abt_pkg::abt_state_e    state_next;
    logic [6:0]             step_div_reg;
    logic [6:0]             steps_left_reg;
    logic [1:0]             extra_left_reg;
    logic [6:0]             convs_left_reg;
    logic                   conv_start_reg;

    // both registers sit on page 0xf, so the page bit qualifies every access
    wire sel_pwr = sfr_page_f && (sfr_addr == abt_pkg::ADDR_POWERUP_TIME);
    wire sel_tk  = sfr_page_f && (sfr_addr == abt_pkg::ADDR_TRACK_TIME);
    wire wr_pwr  = sfr_wr && sel_pwr;
    wire wr_tk   = sfr_wr && sel_tk;

    // reserved bits are simply not stored
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            powerup_delay_field_reg <= abt_pkg::POWERUP_RESET[abt_pkg::POWERUP_MSB:0];
            track_delay_field_reg   <= abt_pkg::TRACK_RESET[abt_pkg::TRACK_MSB:0];
        end else begin
            if (wr_pwr) begin
                powerup_delay_field_reg <= sfr_wdata[abt_pkg::POWERUP_MSB:0];
            end
            if (wr_tk) begin
                track_delay_field_reg <= sfr_wdata[abt_pkg::TRACK_MSB:0];
            end
        end
    end

    // read data is combinational, so a read completes in the cycle it is addressed
    wire [7:0] rd_pwr_word = {4'h_0, powerup_delay_field_reg};
    wire [7:0] rd_tk_word  = {2'h_0, track_delay_field_reg};
    assign sfr_rdata = sel_pwr ? rd_pwr_word :
                       sel_tk  ? rd_tk_word  :
                       8'h_00;

    // repeat code to conversion count; reserved codes run one conversion
    wire [6:0] repeat_count =
        (burst_repeat_field == 3'b001) ? 7'd4  :
        (burst_repeat_field == 3'b010) ? 7'd8  :
        (burst_repeat_field == 3'b011) ? 7'd16 :
        (burst_repeat_field == 3'b100) ? 7'd32 :
        (burst_repeat_field == 3'b101) ? 7'd64 : 7'd1;

    // named state views keep the counter enables short
    wire st_idle    = (state_reg == abt_pkg::ABT_IDLE);
    wire st_powerup = (state_reg == abt_pkg::ABT_POWERUP);
    wire st_track   = (state_reg == abt_pkg::ABT_TRACK);
    wire st_extra   = (state_reg == abt_pkg::ABT_EXTRA);
    wire st_convert = (state_reg == abt_pkg::ABT_CONVERT);

    // one step divider is shared by both delays
    wire       in_delay   = st_powerup || st_track;
    wire [6:0] step_len   = st_powerup ? 7'(abt_pkg::POWERUP_STEP_CYC)
                                       : 7'(abt_pkg::TRACK_STEP_CYC);
    wire       step_tick  = in_delay && (step_div_reg == step_len - 7'd1);
    wire       delay_done = step_tick && (steps_left_reg == 7'd1);
    wire [6:0] pwr_steps  = {3'h_0, powerup_delay_field_reg} + 7'd1;
    wire [6:0] trk_steps  = abt_pkg::TRACK_BASE - {1'b0, track_delay_field_reg};
    wire       extra_done = sar_clk_tick && (extra_left_reg == 2'd1);

    // count is captured at start, so a repeat change mid-burst waits for the next one
    wire       burst_go   = burst_mode_on && start_conv;
    wire       last_conv  = (convs_left_reg == 7'd1);
    wire       warm_start = !converter_enable_bit;
    wire       pre_conv_extra = delayed_tracking_option;

    // next-state logic; every path starts from holding the current state
    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            // only idle listens to start, so starts during a burst are dropped
            abt_pkg::ABT_IDLE: begin
                if (burst_go) begin
                    // no track delay before the first conversion
                    if (warm_start) begin
                        state_next = abt_pkg::ABT_POWERUP;
                    end else if (pre_conv_extra) begin
                        state_next = abt_pkg::ABT_EXTRA;
                    end else begin
                        state_next = abt_pkg::ABT_CONVERT;
                    end
                end
            end
            abt_pkg::ABT_POWERUP, abt_pkg::ABT_TRACK: begin
                if (delay_done) begin
                    state_next = pre_conv_extra ? abt_pkg::ABT_EXTRA : abt_pkg::ABT_CONVERT;
                end
            end
            abt_pkg::ABT_EXTRA: begin
                if (extra_done) begin
                    state_next = abt_pkg::ABT_CONVERT;
                end
            end
            // a done pulse outside a conversion is ignored
            abt_pkg::ABT_CONVERT: begin
                if (conv_done) begin
                    state_next = last_conv ? abt_pkg::ABT_IDLE : abt_pkg::ABT_TRACK;
                end
            end
            default: state_next = abt_pkg::ABT_IDLE;
        endcase
    end

    // reload on entry so a stale count never shortens a delay
    wire entering_delay = (state_next != state_reg) &&
                          ((state_next == abt_pkg::ABT_POWERUP) || (state_next == abt_pkg::ABT_TRACK));

    wire       entering_extra   = (state_next == abt_pkg::ABT_EXTRA) && !st_extra;
    wire       entering_convert = (state_next == abt_pkg::ABT_CONVERT) && !st_convert;
    wire       burst_load       = st_idle && burst_go;
    wire       conv_finished    = st_convert && conv_done;
    wire [6:0] delay_load       = (state_next == abt_pkg::ABT_POWERUP) ? pwr_steps : trk_steps;

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            state_reg <= abt_pkg::ABT_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    // step divider and down-counter; reloaded on every entry into a delay
    always_ff @(posedge clk_sys) begin
        if (sys_rst || entering_delay || !in_delay || step_tick) begin
            step_div_reg <= abt_pkg::STEP_CNT_RESET;
        end else begin
            step_div_reg <= step_div_reg + 7'd1;
        end
    end

    // a field written during a delay only counts from the next load
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            steps_left_reg <= abt_pkg::STEP_CNT_RESET;
        end else if (entering_delay) begin
            steps_left_reg <= delay_load;
        end else if (step_tick) begin
            steps_left_reg <= steps_left_reg - 7'd1;
        end
    end

    // counts sar ticks, so the first of the three may be a partial period
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            extra_left_reg <= 2'd0;
        end else if (entering_extra) begin
            extra_left_reg <= abt_pkg::DELAYED_TRACK_CYC;
        end else if (st_extra && sar_clk_tick) begin
            extra_left_reg <= extra_left_reg - 2'd1;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            convs_left_reg <= 7'd0;
        end else if (burst_load) begin
            convs_left_reg <= repeat_count;
        end else if (conv_finished) begin
            convs_left_reg <= convs_left_reg - 7'd1;
        end
    end

    // registered so the core sees a glitch-free one-cycle pulse
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            conv_start_reg <= 1'b0;
        end else begin
            conv_start_reg <= entering_convert;
        end
    end

    // powered whenever enabled; in burst mode also while a burst is under way
    wire burst_power = converter_enable_bit || !st_idle;
    wire plain_power = converter_enable_bit;

    assign adc_powered     = burst_mode_on ? burst_power : plain_power;
    assign conv_start      = conv_start_reg;
    // the clock switch itself sits in the clock tree; this only requests it
    assign clk_from_lp_osc = burst_mode_on;
    assign burst_busy      = !st_idle;
endmodule
`default_nettype wire

// [tb/abt_sar_model.sv]
`timescale 1ns/1ps
`default_nettype none
module abt_sar_model #(parameter int CONV_CYC = 12) (
    input  wire logic clk_sys,
    input  wire logic conv_start,
    output logic      sar_clk_tick = 1'b0,
    output logic      conv_done = 1'b0
);
    int cnt = 0;
    int div = 0;
    // conversion length is the model's own; the block must not depend on it
    always @(posedge clk_sys) begin
        div <= (div + 1) % 4;
        sar_clk_tick <= (div == 3);
        conv_done <= (cnt == 1);
        if (conv_start)
            cnt <= CONV_CYC;
        else if (cnt > 0)
            cnt <= cnt - 1;
    end
endmodule
`default_nettype wire

// [tb/abt_burst_chk.sv]
`timescale 1ns/1ps
`default_nettype none
module abt_burst_chk (
    input wire logic       clk_sys,
    input wire logic       sys_rst,
    input wire logic [7:0] sfr_addr,
    input wire logic       sfr_page_f,
    input wire logic [7:0] sfr_rdata,
    input wire logic       burst_mode_on,
    input wire logic       converter_enable_bit,
    input wire logic       delayed_tracking_option,
    input wire logic       start_conv,
    input wire logic       adc_powered,
    input wire logic       conv_start,
    input wire logic       clk_from_lp_osc,
    input wire logic       burst_busy
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (sys_rst);
    wire logic pwr_sel = sfr_page_f && sfr_addr == abt_pkg::ADDR_POWERUP_TIME;
    wire logic tk_sel = sfr_page_f && sfr_addr == abt_pkg::ADDR_TRACK_TIME;
    wire logic go = burst_mode_on && start_conv && !burst_busy;
    chk_pwr_rd_zero: assert property (pwr_sel |-> sfr_rdata[7:4] == 4'h_0)
        else $error("power-up upper bits set");
    chk_tk_rd_zero: assert property (tk_sel |-> sfr_rdata[7:6] == 2'h_0)
        else $error("track upper bits set");
    chk_lp_clk_sel: assert property (clk_from_lp_osc == burst_mode_on)
        else $error("clock source wrong");
    chk_idle_follow: assert property (!burst_mode_on && !burst_busy |-> adc_powered == converter_enable_bit)
        else $error("power not following enable");
    chk_stay_pwr: assert property (burst_mode_on && converter_enable_bit |-> adc_powered)
        else $error("powered down with enable set");
    chk_fast_start: assert property (go && converter_enable_bit && !delayed_tracking_option |-> ##[1:2] conv_start)
        else $error("late first conversion");
    chk_sleep_after: assert property ($fell(burst_busy) && burst_mode_on && !converter_enable_bit |-> !adc_powered)
        else $error("no sleep after burst");
    chk_start_pulse: assert property (conv_start |=> !conv_start)
        else $error("start pulse too long");
    chk_conv_powered: assert property (conv_start |-> adc_powered && burst_busy)
        else $error("convert while unpowered");
    cov_start: cover property (conv_start);
    cov_end: cover property ($fell(burst_busy));
    cov_sleep: cover property (go && !converter_enable_bit);
endmodule
bind abt_burst_timing abt_burst_chk u_chk (
    .clk_sys                 (clk_sys),
    .sys_rst                 (sys_rst),
    .sfr_addr                (sfr_addr),
    .sfr_page_f              (sfr_page_f),
    .sfr_rdata               (sfr_rdata),
    .burst_mode_on           (burst_mode_on),
    .converter_enable_bit    (converter_enable_bit),
    .delayed_tracking_option (delayed_tracking_option),
    .start_conv              (start_conv),
    .adc_powered             (adc_powered),
    .conv_start              (conv_start),
    .clk_from_lp_osc         (clk_from_lp_osc),
    .burst_busy              (burst_busy)
);
`default_nettype wire

// [tb/tb.sv]
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic       clk_sys = 0, sys_rst = 1, sfr_page_f = 0, sfr_wr = 0, start_conv = 0;
    logic       burst_mode_on = 0, converter_enable_bit = 0, delayed_tracking_option = 0;
    logic [7:0] sfr_addr = 8'h_00, sfr_wdata = 8'h_00, sfr_rdata, v;
    logic [2:0] burst_repeat_field = 3'h_0;
    logic       sar_clk_tick, conv_done, adc_powered, conv_start, clk_from_lp_osc, burst_busy;
    int         fails = 0, compares = 0, first, gap, n;
    int         reps [8] = '{1, 4, 8, 16, 32, 64, 1, 1};
    abt_burst_timing dut (
        .clk_sys                 (clk_sys),
        .sys_rst                 (sys_rst),
        .sfr_addr                (sfr_addr),
        .sfr_page_f              (sfr_page_f),
        .sfr_wr                  (sfr_wr),
        .sfr_wdata               (sfr_wdata),
        .sfr_rdata               (sfr_rdata),
        .burst_mode_on           (burst_mode_on),
        .converter_enable_bit    (converter_enable_bit),
        .delayed_tracking_option (delayed_tracking_option),
        .burst_repeat_field      (burst_repeat_field),
        .start_conv              (start_conv),
        .sar_clk_tick            (sar_clk_tick),
        .conv_done               (conv_done),
        .adc_powered             (adc_powered),
        .conv_start              (conv_start),
        .clk_from_lp_osc         (clk_from_lp_osc),
        .burst_busy              (burst_busy)
    );
    abt_sar_model sar (
        .clk_sys      (clk_sys),
        .conv_start   (conv_start),
        .sar_clk_tick (sar_clk_tick),
        .conv_done    (conv_done)
    );
    always #2.5 clk_sys = ~clk_sys;
    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
        compares++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] %0t %s got %0h exp %0h", $time, what, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys) #1;
        {sfr_page_f, sfr_addr, sfr_wdata, sfr_wr} = {1'b1, a, d, 1'b1};
        @(posedge clk_sys) #1 sfr_wr = 0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge clk_sys) #1;
        {sfr_page_f, sfr_addr} = {1'b1, a};
        #1 v = sfr_rdata;
    endtask
    // one start pulse, then count until the burst ends or a bound runs out
    task automatic burst(input logic en, input logic tm, input logic [2:0] rpt);
        int t, d;
        {converter_enable_bit, delayed_tracking_option, burst_repeat_field} = {en, tm, rpt};
        burst_mode_on = 1;
        {t, d, n, gap, first} = '0;
        @(posedge clk_sys) #1 start_conv = 1;
        @(posedge clk_sys) #1 start_conv = 0;
        // t counts edges from the one that takes the start
        t = 1;
        while (t < 5000 && (burst_busy === 1'b1 || n == 0)) begin
            if (conv_start === 1'b1) begin
                n++;
                if (n == 1) first = t;
                if (n == 2) gap = t - d;
            end
            if (conv_done === 1'b1) d = t;
            @(posedge clk_sys) #1 t++;
        end
    endtask
    task automatic t_regs;
        rd(8'h_BA); check(v, 8'h_0F, "pwr reset");
        rd(8'h_BD); check(v, 8'h_16, "trk reset");
        rd(8'h_BB); check(v, 8'h_00, "unmapped");
        wr(8'h_BA, 8'h_F5); rd(8'h_BA); check(v, 8'h_05, "pwr mask");
        wr(8'h_BD, 8'h_FF); rd(8'h_BD); check(v, 8'h_3F, "trk mask");
        $display("t_regs done");
    endtask
    task automatic t_nonburst;
        burst_mode_on = 0;
        for (int e = 0; e < 2; e++) begin
            converter_enable_bit = e[0];
            @(posedge clk_sys) #1 start_conv = 1;
            @(posedge clk_sys) #1 start_conv = 0;
            check(adc_powered, e[0], "power follows");
            check({burst_busy, clk_from_lp_osc}, 0, "start ignored");
        end
        $display("t_nonburst done");
    endtask
    task automatic t_fast;
        burst(1, 0, 3'h_1);
        check(first inside {[1:2]}, 1, "no delay");
        check(gap inside {[10:12]}, 1, "short gap");
        check({n, adc_powered, clk_from_lp_osc}, {32'd4, 2'b11}, "stay on");
        burst(1, 1, 3'h_1);
        check(first inside {[9:14]}, 1, "extra track");
        check(gap inside {[19:26]}, 1, "extra gap");
        $display("t_fast done");
    endtask
    task automatic t_sleep;
        wr(8'h_BA, 8'h_00);
        wr(8'h_BD, 8'h_00);
        burst(0, 0, 3'h_1);
        check(first inside {[80:83]}, 1, "min powerup");
        check(gap inside {[640:642]}, 1, "long gap");
        check(adc_powered, 0, "sleep");
        wr(8'h_BA, 8'h_0F);
        wr(8'h_BD, 8'h_3F);
        burst(0, 0, 3'h_0);
        check(first inside {[1280:1283]}, 1, "max powerup");
        $display("t_sleep done");
    endtask
    task automatic t_reps;
        for (int r = 0; r < 8; r++) begin
            burst(1, 0, r[2:0]);
            check(n, reps[r], "repeat count");
        end
        $display("t_reps done");
    endtask
    task automatic end_sim;
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    initial begin
        repeat (16) @(posedge clk_sys);
        #1 sys_rst = 0;
        t_regs;
        t_nonburst;
        t_fast;
        t_sleep;
        t_reps;
        end_sim;
    end
    initial begin
        #200_000;
        fails++;
        end_sim;
    end
endmodule
`default_nettype wire
